/* File: common/dfir_regs.vh */
// Purpose: Constants for the drive fault indication and reset block.
// Assumes: APB with 32-bit data, 40 MHz pclk.
// Notes:   All offsets are byte addresses of aligned words.
`ifndef DFIR_REGS_VH
`define DFIR_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DFIR_OFS_CTRL     12'h000
`define DFIR_OFS_FAULT    12'h004
`define DFIR_OFS_STATUS   12'h008
`define DFIR_OFS_ENTRY    12'h00C
`define DFIR_OFS_CARD     12'h010
`define DFIR_OFS_PARAM    12'h014
`define DFIR_OFS_CARDSUM  12'h018
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DFIR_CTRL_SRC_LSB   0
`define DFIR_CTRL_AUTO_BIT  2
`define DFIR_CTRL_BUSRST    3
`define DFIR_CTRL_KPAD_BIT  4
`define DFIR_CTRL_RESET     5'h00
`define DFIR_SRC_TERM       2'h0
`define DFIR_SRC_KEYPAD     2'h1
`define DFIR_SRC_BUS        2'h2
// ----------------------------------------
// Fault classes and keypad codes
// ----------------------------------------
`define DFIR_CLS_OTHER      3'h0
`define DFIR_CLS_UNDERV     3'h1
`define DFIR_CLS_OVERC      3'h2
`define DFIR_CLS_OVERV      3'h3
`define DFIR_CLS_MOTOL      3'h4
`define DFIR_CLS_DEVOL      3'h5
`define DFIR_CLS_MOTOT      3'h6
`define DFIR_CLS_CTLOT      3'h7
`define DFIR_CODE_NONE      4'h0
`define DFIR_CODE_OTHER     4'h1
`define DFIR_CODE_UNDERV    4'h2
`define DFIR_CODE_OVERC     4'h3
`define DFIR_CODE_OVERV     4'h4
`define DFIR_CODE_MOTOL     4'h5
`define DFIR_CODE_DEVOL     4'h6
`define DFIR_CODE_MOTOT     4'h7
`define DFIR_CODE_CTLOT     4'h8
// ----------------------------------------
// Entry and card error bit positions
// ----------------------------------------
`define DFIR_ENT_NOT_EDIT   0
`define DFIR_ENT_CTRL_REF   1
`define DFIR_ENT_CTRL_FLT   2
`define DFIR_ENT_IMPERM     3
`define DFIR_ENT_HIGH       4
`define DFIR_ENT_LOW        5
`define DFIR_ENT_CARD_REF   6
`define DFIR_ENT_PASSWORD   7
`define DFIR_CRD_WPROT      0
`define DFIR_CRD_PLAUS      1
`define DFIR_CRD_TYPE       2
`define DFIR_CRD_INCOMP     3
`define DFIR_CRD_LINK       4
`define DFIR_CRD_CHKSUM     5
`define DFIR_CRD_FULL       6
`define DFIR_CRD_AREA       7
// ----------------------------------------
// Timing
// ----------------------------------------
`define DFIR_CLK_HZ         40000000
`define DFIR_HOLD_MS        3000
`define DFIR_HOLD_CYC       ((`DFIR_CLK_HZ / 1000) * `DFIR_HOLD_MS)
`define DFIR_BLINK_MS       200
`define DFIR_BLINK_CYC      ((`DFIR_CLK_HZ / 1000) * `DFIR_BLINK_MS)
`define DFIR_PAUSE_HALVES   8
`endif

/* File: verilog/dfir_fault_unit.v */
// Purpose: Fault latching, blink code, fault response and error reset.
// Assumes: One clock pclk at 40 MHz; terminal and key inputs are asynchronous.
// Notes:   Registers are reached over APB; long timers are parameters.
//
// Functional notes
// - Red indicator blinks burst count per class.
// - Keypad shows abbreviation code of active error.
// - Other errors: one blink (none at response zero), response zero to five.
// - Undervoltage: two blinks, response one.
// - Overcurrent: three blinks, response three.
// - Overvoltage: four blinks, response three.
// - Motor overload: five blinks, response three.
// - Device overload: six blinks, response three.
// - Motor overtemperature: seven blinks, response three.
// - Controller overtemperature: eight blinks, response three.
// - Terminal: enable rising edge resets, disables control.
// - Terminal: error-reset input level resets responses 1-4.
// - Keypad: stop key held three seconds resets.
// - Fieldbus control-word reset bit resets responses 1-4.
// - Autostart restarts after reset of response 1, 2.
// - Responses 3, 4 need start withdrawn and reapplied.
// - Response five ignores every reset source.
// - Entry error codes cleared by start/enter.
// - Parameter value checked: impermissible, high, low.
// - Card transfer error codes cleared by stop/return.
// - Card checksum mismatch raises invalid-data code.
// - Response zero warns; one disables power stage.
// - Response two quick-stops, waits start cancel.
// - Three disables and lock_after_quickstop_response; four quick-stops, lock_after_quickstop_response.
//
// Design decisions made here: the APB interface to the registers and the address map.
`include "dfir_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module dfir_fault_unit #(
    parameter integer HOLD_CYC  = `DFIR_HOLD_CYC,
    parameter integer BLINK_CYC = `DFIR_BLINK_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  fault_req,
    input  wire [2:0]  other_resp,
    input  wire        power_stage_enable_input,
    input  wire        error_reset_input_function,
    input  wire        stop_key,
    input  wire        enter_key,
    input  wire        start_signal,
    output reg         red_fault_indicator,
    output reg  [3:0]  keypad_code,
    output reg         power_stage_on,
    output reg         quick_stop,
    output reg         warning,
    output reg         drive_run
);

    // ------------------------------------
    // Declarations
    // ------------------------------------
    reg  [4:0]  ctrl;
    reg  [7:0]  entry_err;
    reg  [7:0]  card_err;
    reg  [31:0] param_lim;
    reg         fault_act;
    reg  [2:0]  fault_cls;
    reg  [2:0]  fault_resp;
    reg         lock_restart;
    reg         wait_cancel;
    reg  [4:0]  sync1;
    reg  [4:0]  sync2;
    reg  [4:0]  prev;
    reg  [31:0] hold_cnt;
    reg  [31:0] tick_cnt;
    reg  [4:0]  phase;
    reg  [3:0]  blink_done;
    reg         bus_reset_req;
    wire        en_s;
    wire        rs_s;
    wire        stop_s;
    wire        ent_s;
    wire        start_s;
    wire        wr;
    wire        tick;
    wire        reset_hit;
    wire [2:0]  req_cls;
    wire        req_any;
    wire [2:0]  req_resp;
    wire [3:0]  burst;
    wire [15:0] pval;

    assign en_s    = sync2[0];
    assign rs_s    = sync2[1];
    assign stop_s  = sync2[2];
    assign ent_s   = sync2[3];
    assign start_s = sync2[4];
    assign wr      = psel & penable & pwrite;
    assign pval    = pwdata[15:0];

    // ------------------------------------
    // Class decoding
    // ------------------------------------
    // Fixed response per class; other errors take the given response, limited to five.
    function [2:0] dfir_resp;
        input [2:0] cls;
        input [2:0] oth;
        begin
            case (cls)
                `DFIR_CLS_OTHER:  dfir_resp = (oth > 3'h5) ? 3'h5 : oth;
                `DFIR_CLS_UNDERV: dfir_resp = 3'h1;
                default:          dfir_resp = 3'h3;
            endcase
        end
    endfunction

    // Class index plus one is the blink burst count.
    assign burst    = {1'b0, fault_cls} + 4'h1;
    assign req_any  = |fault_req;
    assign req_cls  = fault_req[7] ? 3'h7 : fault_req[6] ? 3'h6 : fault_req[5] ? 3'h5 :
                      fault_req[4] ? 3'h4 : fault_req[3] ? 3'h3 : fault_req[2] ? 3'h2 :
                      fault_req[1] ? 3'h1 : 3'h0;
    assign req_resp = dfir_resp(req_cls, other_resp);

    // ------------------------------------
    // Input synchronisers
    // ------------------------------------
    // Two flip-flops for each asynchronous input, then an edge history.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            prev  <= 5'h00;
        end else begin
            sync1 <= {start_signal, enter_key, stop_key, error_reset_input_function,
                      power_stage_enable_input};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // ------------------------------------
    // Reset sources
    // ------------------------------------
    // Counts the time the stop key stays pressed.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 32'h0000_0000;
        end else if (!stop_s) begin
            hold_cnt <= 32'h0000_0000;
        end else if (hold_cnt < HOLD_CYC) begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
        end
    end

    // Selects the reset source that belongs to the active control location.
    assign reset_hit =
        (ctrl[1:0] == `DFIR_SRC_TERM)   ? ((en_s & ~prev[0]) | rs_s) :
        (ctrl[1:0] == `DFIR_SRC_KEYPAD) ? (hold_cnt == HOLD_CYC - 1) :
        (ctrl[1:0] == `DFIR_SRC_BUS)    ? bus_reset_req : 1'b0;

    // ------------------------------------
    // Fault latch and response
    // ------------------------------------
    // A fault stays latched until a reset fits its response; a new fault wins unless a response-five fault is latched.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_act    <= 1'b0;
            fault_cls    <= `DFIR_CLS_OTHER;
            fault_resp   <= 3'h0;
            lock_restart <= 1'b0;
            wait_cancel  <= 1'b0;
        end else begin
            if (req_any && !(fault_act && fault_resp == 3'h5)) begin
                fault_act  <= 1'b1;
                fault_cls  <= req_cls;
                fault_resp <= req_resp;
            end else if (fault_act && reset_hit && fault_resp != 3'h5 &&
                         fault_resp != 3'h0) begin
                fault_act <= 1'b0;
                // Without autostart every restart needs a new start edge.
                lock_restart <= !ctrl[`DFIR_CTRL_AUTO_BIT] || fault_resp[2] ||
                                fault_resp == 3'h3;
            end else if (fault_act && fault_resp == 3'h0 && reset_hit) begin
                fault_act <= 1'b0;
            end
            if (req_any && (req_resp == 3'h2 || req_resp == 3'h4)) begin
                wait_cancel <= 1'b1;
            end else if (!start_s) begin
                wait_cancel <= 1'b0;
            end
            if (lock_restart && !start_s && !(fault_act && reset_hit)) begin
                lock_restart <= 1'b0;
            end
        end
    end

    // ------------------------------------
    // Blink sequencer
    // ------------------------------------
    // Half-period ticks; odd phases light the indicator, then a dark pause.
    assign tick = (tick_cnt == BLINK_CYC - 1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt   <= 32'h0000_0000;
            phase      <= 5'h00;
            blink_done <= 4'h0;
        end else if (!fault_act || fault_resp == 3'h0) begin
            tick_cnt   <= 32'h0000_0000;
            phase      <= 5'h00;
            blink_done <= 4'h0;
        end else begin
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            if (tick) begin
                if (blink_done == burst && phase[0] == 1'b0 &&
                    phase == `DFIR_PAUSE_HALVES) begin
                    phase      <= 5'h00;
                    blink_done <= 4'h0;
                end else if (blink_done == burst) begin
                    phase <= phase + 5'h01;
                end else begin
                    phase <= phase[0] ? 5'h00 : 5'h01;
                    if (phase[0]) begin
                        blink_done <= blink_done + 4'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------
    // Output stage
    // ------------------------------------
    // All outputs come from flip-flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            red_fault_indicator <= 1'b0;
            keypad_code         <= `DFIR_CODE_NONE;
            power_stage_on      <= 1'b0;
            quick_stop          <= 1'b0;
            warning             <= 1'b0;
            drive_run           <= 1'b0;
        end else begin
            red_fault_indicator <= fault_act && fault_resp != 3'h0 &&
                                   blink_done != burst && phase[0];
            keypad_code <= (fault_act && ctrl[`DFIR_CTRL_KPAD_BIT]) ?
                           {1'b0, fault_cls} + 4'h1 : `DFIR_CODE_NONE;
            warning     <= fault_act && fault_resp == 3'h0;
            // Responses one, three and five cut the power stage at once.
            power_stage_on <= en_s && !(fault_act && fault_resp != 3'h0 &&
                              !(fault_resp == 3'h2 || fault_resp == 3'h4)) &&
                              !(ctrl[1:0] == `DFIR_SRC_TERM && en_s && !prev[0]);
            quick_stop  <= fault_act && (fault_resp == 3'h2 || fault_resp == 3'h4);
            drive_run   <= start_s && en_s && !lock_restart && !wait_cancel &&
                           !(fault_act && fault_resp != 3'h0);
        end
    end

    // ------------------------------------
    // Entry and card error codes
    // ------------------------------------
    // Software sets codes by writes; keys clear their group, set wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_err <= 8'h00;
            card_err  <= 8'h00;
        end else begin
            if (wr && paddr == `DFIR_OFS_ENTRY) begin
                entry_err <= entry_err | pwdata[7:0];
            end else if (wr && paddr == `DFIR_OFS_PARAM) begin
                // Limit check: low half minimum, high half maximum, top bit reject.
                entry_err[`DFIR_ENT_IMPERM] <= entry_err[`DFIR_ENT_IMPERM] | pwdata[31];
                entry_err[`DFIR_ENT_HIGH]   <= entry_err[`DFIR_ENT_HIGH] | (pval > param_lim[31:16]);
                entry_err[`DFIR_ENT_LOW]    <= entry_err[`DFIR_ENT_LOW] | (pval < param_lim[15:0]);
            end else if (ent_s && !prev[3]) begin
                entry_err <= 8'h00;
            end
            if (wr && paddr == `DFIR_OFS_CARD) begin
                card_err <= card_err | pwdata[7:0];
            end else if (wr && paddr == `DFIR_OFS_CARDSUM) begin
                card_err[`DFIR_CRD_CHKSUM] <= card_err[`DFIR_CRD_CHKSUM] |
                                              (pwdata[15:0] != pwdata[31:16]);
            end else if (stop_s && !prev[2]) begin
                card_err <= 8'h00;
            end
        end
    end

    // ------------------------------------
    // APB slave
    // ------------------------------------
    // Zero-wait slave; unmapped addresses answer with pslverr.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl          <= `DFIR_CTRL_RESET;
            param_lim     <= 32'hFFFF_0000;
            bus_reset_req <= 1'b0;
            prdata        <= 32'h0000_0000;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
        end else begin
            pready        <= psel & ~penable;
            pslverr       <= 1'b0;
            bus_reset_req <= 1'b0;
            prdata        <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `DFIR_OFS_CTRL: begin
                        if (pwrite) begin
                            ctrl          <= {pwdata[4], 1'b0, pwdata[2:0]};
                            bus_reset_req <= pwdata[`DFIR_CTRL_BUSRST];
                        end
                        prdata <= {27'h0, ctrl};
                    end
                    `DFIR_OFS_FAULT:   prdata <= {20'h0, 1'b0, fault_resp, 1'b0, fault_cls, 3'h0, fault_act};
                    `DFIR_OFS_STATUS:  prdata <= {24'h0, 2'h0, drive_run, warning, quick_stop,
                                                  power_stage_on, wait_cancel, lock_restart};
                    `DFIR_OFS_ENTRY:   prdata <= {24'h0, entry_err};
                    `DFIR_OFS_CARD:    prdata <= {24'h0, card_err};
                    `DFIR_OFS_PARAM:   prdata <= param_lim;
                    `DFIR_OFS_CARDSUM: prdata <= 32'h0000_0000;
                    default:           pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: tb/dfir_operator.sv */
// Purpose: Operator side of the fault unit: terminals, keypad keys and start.
// Assumes: Lines change just after a rising edge of pclk.
// Notes:   Bit 0 enable, 1 error reset, 2 stop, 3 enter, 4 start.
`timescale 1ns/10ps
`default_nettype none
module dfir_operator (
    input  wire logic       pclk,
    output var  logic [4:0] lines
);
    // Enable is applied and every other line released at power-up.
    initial lines = 5'h01;
    // Drives one line to a level just after a rising edge.
    task automatic drive_line(input int i, input logic v);
        @(posedge pclk);
        lines[i] <= v;
    endtask
    // Holds one key or input active for n cycles, then lets go.
    task automatic press(input int i, input int n);
        drive_line(i, 1'h1);
        repeat (n) @(posedge pclk);
        lines[i] <= 1'h0;
    endtask
    // Withdraws the start signal and applies it again.
    task automatic restart();
        drive_line(4, 1'h0);
        repeat (4) @(posedge pclk);
        lines[4] <= 1'h1;
    endtask
endmodule
`default_nettype wire

/* File: tb/dfir_fault_chk.sv */
// Purpose: Port-level assertions for the fault unit.
// Assumes: The control word is shadowed from APB writes at the setup edge.
// Notes:   Burst counts are judged only while the keypad is attached.
`timescale 1ns/10ps
`default_nettype none
`include "dfir_regs.vh"
module dfir_fault_chk #(
    parameter int BLINK_CYC = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        power_stage_enable_input,
    input wire logic        red_fault_indicator,
    input wire logic [3:0]  keypad_code,
    input wire logic        drive_run
);
    logic [4:0]  ctrl_q;
    logic [31:0] hi_cnt;
    logic [31:0] lo_cnt;
    logic [3:0]  bursts;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Tracks the control word, the indicator run lengths and the blinks of a burst.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 5'h00;
            hi_cnt <= 32'h0;
            lo_cnt <= 32'h0;
            bursts <= 4'h0;
        end else begin
            if (psel && !penable && pwrite && paddr == `DFIR_OFS_CTRL)
                ctrl_q <= pwdata[4:0];
            hi_cnt <= red_fault_indicator ? hi_cnt + 32'h1 : 32'h0;
            lo_cnt <= red_fault_indicator ? 32'h0 : lo_cnt + 32'h1;
            if (keypad_code == 4'h0)
                bursts <= 4'h0;
            else if ($rose(red_fault_indicator))
                bursts <= (lo_cnt > BLINK_CYC) ? 4'h1 : bursts + 4'h1;
        end
    end
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    unmapped_err_a: assert property (psel && !penable && paddr > 12'h018 |=> pready && pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && !penable && paddr <= 12'h018 |=> !pslverr)
        else $error("mapped access refused");
    keypad_code_a: assert property (keypad_code != 4'h0 |-> keypad_code <= 4'h8 && (ctrl_q[4] || $past(ctrl_q[4])))
        else $error("keypad code out of place");
    blink_high_a: assert property ($fell(red_fault_indicator) && keypad_code != 4'h0 |-> hi_cnt == BLINK_CYC)
        else $error("indicator lit time wrong");
    blink_gap_a: assert property ($rose(red_fault_indicator) |-> lo_cnt >= BLINK_CYC)
        else $error("indicator dark time too short");
    burst_count_a: assert property ($rose(red_fault_indicator) && lo_cnt > BLINK_CYC && bursts != 4'h0
                                    && ctrl_q[4] |-> bursts == keypad_code)
        else $error("burst count does not match class");
    enable_edge_a: assert property ($rose(power_stage_enable_input) && ctrl_q[1:0] == `DFIR_SRC_TERM
                                    |-> ##[3:6] !drive_run)
        else $error("enable edge left control on");
    cover property ($rose(red_fault_indicator) && lo_cnt > BLINK_CYC && bursts == 4'h8);
    cover property (psel && !penable && paddr > 12'h018);
    cover property ($rose(drive_run));
endmodule
bind dfir_fault_unit dfir_fault_chk #(.BLINK_CYC(BLINK_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .power_stage_enable_input(power_stage_enable_input), .red_fault_indicator(red_fault_indicator),
    .keypad_code(keypad_code), .drive_run(drive_run)
);
`default_nettype wire

/* File: tb/drive_fault_indication_reset_tb.sv */
// Purpose: Self-checking bench for the fault unit.
// Assumes: Hold and blink counts are shortened by parameter.
// Notes:   Scenarios run in order; a watchdog ends a hang.
`timescale 1ns/10ps
`default_nettype none
`include "dfir_regs.vh"
module drive_fault_indication_reset_tb;
    localparam int HOLD  = 50;
    localparam int BLINK = 4;
    logic        pclk        = 1'h0;
    logic        presetn     = 1'h0;
    logic        psel        = 1'h0;
    logic        penable     = 1'h0;
    logic        pwrite      = 1'h0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0;
    logic [7:0]  fault_req   = 8'h00;
    logic [2:0]  other_resp  = 3'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, red, psu, qstop, warn, run;
    logic [3:0]  kcode;
    logic [4:0]  lines;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    dfir_fault_unit #(.HOLD_CYC(HOLD), .BLINK_CYC(BLINK)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_req(fault_req), .other_resp(other_resp), .power_stage_enable_input(lines[0]),
        .error_reset_input_function(lines[1]), .stop_key(lines[2]), .enter_key(lines[3]),
        .start_signal(lines[4]), .red_fault_indicator(red), .keypad_code(kcode),
        .power_stage_on(psu), .quick_stop(qstop), .warning(warn), .drive_run(run)
    );
    dfir_operator op (.pclk(pclk), .lines(lines));
    // Free-running bus clock.
    initial forever #12.5 pclk = ~pclk;
    // Counts one comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Waits n edges and settles at the following falling edge.
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic e;
        apb(1'h1, a, d, e);
    endtask
    task automatic rd(input logic [11:0] a);
        logic e;
        apb(1'h0, a, 32'h0, e);
    endtask
    // Raises one fault class briefly, then lets the blink code run.
    task automatic fault(input int c, input logic [2:0] r);
        @(posedge pclk);
        fault_req <= 8'h01 << c;
        other_resp <= r;
        repeat (3) @(posedge pclk);
        fault_req <= 8'h00;
        idle(150);
    endtask
    task automatic t_classes();
        logic [2:0] r;
        wr(`DFIR_OFS_CTRL, 32'h00000010);
        for (int c = 0; c < 8; c++) begin
            r = (c == 0) ? 3'h2 : (c == 1) ? 3'h1 : 3'h3;
            fault(c, 3'h2);
            rd(`DFIR_OFS_FAULT);
            chk("fault word", {21'h0, r, 1'h0, c[2:0], 3'h0, 1'h1}, q);
            chk("keypad code", {28'h0, c[3:0] + 4'h1}, {28'h0, kcode});
            op.press(1, 4);
            idle(6);
            rd(`DFIR_OFS_FAULT);
            chk("input reset", 32'h0, {31'h0, q[0]});
        end
        $display("classes done");
    endtask
    task automatic t_codes();
        logic e;
        wr(`DFIR_OFS_ENTRY, 32'h000000FF);
        rd(`DFIR_OFS_ENTRY);
        chk("entry codes", 32'h000000FF, q);
        op.press(3, 2);
        idle(6);
        rd(`DFIR_OFS_ENTRY);
        chk("entry cleared", 32'h00000000, q);
        wr(`DFIR_OFS_PARAM, 32'h80000000);
        rd(`DFIR_OFS_ENTRY);
        chk("value refused", 32'h00000008, q);
        wr(`DFIR_OFS_CARD, 32'h000000DF);
        wr(`DFIR_OFS_CARDSUM, 32'h12341235);
        rd(`DFIR_OFS_CARD);
        chk("card codes", 32'h000000FF, q);
        op.press(2, 2);
        idle(6);
        rd(`DFIR_OFS_CARD);
        chk("card cleared", 32'h00000000, q);
        apb(1'h0, 12'h01C, 32'h0, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("codes done");
    endtask
    task automatic t_keypad();
        wr(`DFIR_OFS_CTRL, 32'h00000011);
        fault(2, 3'h0);
        op.press(2, HOLD / 2);
        idle(6);
        rd(`DFIR_OFS_FAULT);
        chk("short hold", 32'h1, {31'h0, q[0]});
        op.press(2, HOLD + 10);
        idle(6);
        rd(`DFIR_OFS_FAULT);
        chk("long hold", 32'h0, {31'h0, q[0]});
        $display("keypad done");
    endtask
    task automatic t_auto();
        wr(`DFIR_OFS_CTRL, 32'h00000006);
        op.restart();
        idle(8);
        chk("run started", 32'h1, {31'h0, run});
        fault(1, 3'h0);
        chk("stage off", 32'h0, {31'h0, psu});
        wr(`DFIR_OFS_CTRL, 32'h0000000E);
        idle(8);
        chk("auto restart", 32'h1, {31'h0, run});
        fault(2, 3'h0);
        wr(`DFIR_OFS_CTRL, 32'h0000000E);
        idle(8);
        rd(`DFIR_OFS_FAULT);
        chk("bus reset", 32'h0, {31'h0, q[0]});
        chk("restart locked", 32'h0, {31'h0, run});
        op.restart();
        idle(8);
        chk("run after start", 32'h1, {31'h0, run});
        $display("autostart done");
    endtask
    task automatic t_enable();
        wr(`DFIR_OFS_CTRL, 32'h00000000);
        fault(3, 3'h0);
        op.drive_line(0, 1'h0);
        idle(4);
        op.drive_line(0, 1'h1);
        idle(8);
        rd(`DFIR_OFS_FAULT);
        chk("enable reset", 32'h0, {31'h0, q[0]});
        chk("control off", 32'h0, {31'h0, run});
        $display("enable done");
    endtask
    task automatic t_fatal();
        fault(0, 3'h5);
        op.press(1, 4);
        wr(`DFIR_OFS_CTRL, 32'h0000000A);
        idle(8);
        rd(`DFIR_OFS_FAULT);
        chk("fatal held", 32'h00000501, q);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rd(`DFIR_OFS_FAULT);
        chk("power cycle", 32'h0, {31'h0, q[0]});
        $display("fatal done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Ends a hang after 80000 cycles.
    initial begin
        #2000000;
        n_mismatch++;
        test_done();
    end
    // Main sequence after the reset hold.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_classes();
        t_codes();
        t_keypad();
        t_auto();
        t_enable();
        t_fatal();
        test_done();
    end
endmodule
`default_nettype wire
